// File: csb_pkg.sv
// csb_pkg: shared types and constants for the cpu sideband control block
// assumes a single 10 MHz core clock; no software-reachable registers
package csb_pkg;

  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SYNC_STAGES = 2;
  // reset sequence length after power good, in cycles
  localparam int unsigned RESET_SEQ_CYCLES = 8;
  localparam logic [31:0] RESET_VECTOR = 32'hFFFF_FFF0;
  localparam logic [3:0] INT_REG_RESET = 4'h0;

  typedef enum logic [1:0] {
    CSB_PWR_OFF,
    CSB_PWR_SEQ,
    CSB_PWR_RUN
  } csb_pwr_state_t;

  typedef enum logic [1:0] {
    CSB_ACTIVE,
    CSB_STOP_GRANT,
    CSB_DEEP_IDLE,
    CSB_DEEPEST_DOWN
  } csb_cstate_t;

  // synchronized sideband inputs
  typedef struct packed {
    logic power_good;
    logic stop_req;
    logic soft_init;
    logic pin0;
    logic pin1;
  } csb_pins_t;

  // interrupt requests passed to the core
  typedef struct packed {
    logic maskable;
    logic non_maskable;
    logic local0;
    logic local1;
  } csb_irq_t;

endpackage : csb_pkg

// File: csb_sideband.sv
// csb_sideband: power good qualification, stop clock, soft init,
// pending break and local interrupt pin routing.
// assumes raw pins are asynchronous and are synchronized here.
`timescale 1ns/1ps

// Notes on behaviour
// - pending break stays deasserted whenever stop clock is not requested.
// - pending break may request return to active even from deep states.
// - soft init resets integer state; caches and float state untouched.
// - after soft init, fetch restarts from the reset vector.
// - snoops keep being serviced throughout soft init.
// - controller disabled: pin zero becomes a maskable interrupt request.
// - controller disabled: pin one becomes a non-maskable interrupt.
// - controller enable is the inverse of the lic_disable_in input; driving it high selects legacy.
// - stop request enters stop grant, acknowledges, gates core clocks.
module csb_sideband (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // platform pins
  input wire logic power_good_in,
  input wire logic stop_clock_request_n_in,
  input wire logic soft_init_n_in,
  input wire logic local_irq_pin0_in,
  input wire logic local_irq_pin1_in,
  // core side
  input wire logic lic_disable_in,
  input wire logic break_event_in,
  input wire logic deep_idle_req_in,
  input wire logic deepest_down_req_in,
  input wire logic snoop_req_in,
  // outputs
  output logic pending_break_out_n,
  output logic pending_break_oe_n_out,
  output logic stop_grant_ack_out,
  output logic core_clk_gate_out,
  output logic core_reset_out,
  output logic int_reg_reset_out,
  output logic fetch_restart_out,
  output logic [31:0] fetch_addr_out,
  output logic snoop_ack_out,
  output logic [3:0] irq_out,
  output logic [1:0] cstate_out
);

  logic [4:0] sync1;
  logic [4:0] sync2;
  csb_pkg::csb_pins_t pins;
  csb_pkg::csb_pwr_state_t pwr, next_pwr;
  csb_pkg::csb_cstate_t cst, next_cst;
  logic [3:0] seq_cnt, next_seq_cnt;
  logic init_d, next_init_d;
  logic brk_oe_n, next_brk_oe_n;
  logic ack, next_ack;
  logic gate, next_gate;
  logic crst, next_crst;
  logic irst, next_irst;
  logic restart, next_restart;
  logic snoop, next_snoop;
  csb_pkg::csb_irq_t irq, next_irq;

  // all checks below run on the core clock
  default clocking cb_core @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  // two-stage synchronizer per pin
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
    end else begin
      sync1 <= {power_good_in, ~stop_clock_request_n_in, ~soft_init_n_in,
                local_irq_pin0_in, local_irq_pin1_in};
      sync2 <= sync1;
    end
  end

  assign pins = sync2;

  // power good qualification
  always_comb begin
    next_pwr = pwr;
    next_seq_cnt = seq_cnt;
    case (pwr)
      csb_pkg::CSB_PWR_OFF: begin
        next_seq_cnt = 4'h0;
        if (pins.power_good) begin
          next_pwr = csb_pkg::CSB_PWR_SEQ;
        end
      end
      csb_pkg::CSB_PWR_SEQ: begin
        next_seq_cnt = seq_cnt + 4'h1;
        if (seq_cnt == 4'(csb_pkg::RESET_SEQ_CYCLES - 1)) begin
          next_pwr = csb_pkg::CSB_PWR_RUN;
        end
      end
      csb_pkg::CSB_PWR_RUN: next_pwr = csb_pkg::CSB_PWR_RUN;
      default: next_pwr = csb_pkg::CSB_PWR_OFF;
    endcase
    if (!pins.power_good) begin
      next_pwr = csb_pkg::CSB_PWR_OFF;
    end
  end

  wire run = (pwr == csb_pkg::CSB_PWR_RUN);

  // power state, init, break and interrupt logic
  always_comb begin
    next_cst = cst;
    next_init_d = pins.soft_init;
    next_crst = !run;
    next_irst = !run || pins.soft_init;
    next_restart = run && init_d && !pins.soft_init;
    next_snoop = run && snoop_req_in;
    next_brk_oe_n = 1'b1;
    next_ack = 1'b0;
    next_gate = 1'b0;
    if (!run || !pins.stop_req) begin
      next_cst = csb_pkg::CSB_ACTIVE;
    end else begin
      case (cst)
        csb_pkg::CSB_ACTIVE: next_cst = csb_pkg::CSB_STOP_GRANT;
        csb_pkg::CSB_STOP_GRANT: begin
          if (deepest_down_req_in) begin
            next_cst = csb_pkg::CSB_DEEPEST_DOWN;
          end else if (deep_idle_req_in) begin
            next_cst = csb_pkg::CSB_DEEP_IDLE;
          end
        end
        csb_pkg::CSB_DEEP_IDLE: begin
          if (deepest_down_req_in) begin
            next_cst = csb_pkg::CSB_DEEPEST_DOWN;
          end
        end
        csb_pkg::CSB_DEEPEST_DOWN: next_cst = csb_pkg::CSB_DEEPEST_DOWN;
        default: next_cst = csb_pkg::CSB_ACTIVE;
      endcase
      next_ack = 1'b1;
      next_gate = 1'b1;
      next_brk_oe_n = !break_event_in;
    end
    next_irq.maskable = run && lic_disable_in && pins.pin0;
    next_irq.non_maskable = run && lic_disable_in && pins.pin1;
    next_irq.local0 = run && !lic_disable_in && pins.pin0;
    next_irq.local1 = run && !lic_disable_in && pins.pin1;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pwr <= csb_pkg::CSB_PWR_OFF;
      seq_cnt <= 4'h0;
      cst <= csb_pkg::CSB_ACTIVE;
      init_d <= 1'b0;
      brk_oe_n <= 1'b1;
      ack <= 1'b0;
      gate <= 1'b0;
      crst <= 1'b1;
      irst <= 1'b1;
      restart <= 1'b0;
      snoop <= 1'b0;
      irq <= 4'h0;
    end else begin
      pwr <= next_pwr;
      seq_cnt <= next_seq_cnt;
      cst <= next_cst;
      init_d <= next_init_d;
      brk_oe_n <= next_brk_oe_n;
      ack <= next_ack;
      gate <= next_gate;
      crst <= next_crst;
      irst <= next_irst;
      restart <= next_restart;
      snoop <= next_snoop;
      irq <= next_irq;
    end
  end

  // open drain: low enable drives the pin low
  assign pending_break_out_n = 1'b0;
  assign pending_break_oe_n_out = brk_oe_n;
  assign stop_grant_ack_out = ack;
  assign core_clk_gate_out = gate;
  assign core_reset_out = crst;
  assign int_reg_reset_out = irst;
  assign fetch_restart_out = restart;
  assign fetch_addr_out = csb_pkg::RESET_VECTOR;
  assign snoop_ack_out = snoop;
  assign irq_out = irq;
  assign cstate_out = cst;

  a_break_needs_stop: assert property (
    !pins.stop_req |=> pending_break_oe_n_out)
    else $error("pending break asserted without stop request");

  a_break_from_deep: assert property (
    (run && pins.stop_req && break_event_in) |=> !pending_break_oe_n_out)
    else $error("break not driven while stop granted");

  a_init_resets_int: assert property (
    pins.soft_init |=> int_reg_reset_out)
    else $error("soft init did not reset integer state");

  sequence s_init_end;
    init_d && !pins.soft_init && run;
  endsequence
  a_init_restart: assert property (
    s_init_end |=> fetch_restart_out)
    else $error("no restart after soft init");

  a_snoop_in_init: assert property (
    (run && snoop_req_in && pins.soft_init) |=> snoop_ack_out)
    else $error("snoop dropped during soft init");

  a_pin0_maskable: assert property (
    (run && lic_disable_in) |=> irq_out[3] == $past(pins.pin0))
    else $error("pin zero not routed as maskable request");

  a_pin1_nmi: assert property (
    (run && lic_disable_in) |=> irq_out[2] == $past(pins.pin1))
    else $error("pin one not routed as non-maskable request");

  a_local_default: assert property (
    !lic_disable_in |=> irq_out[3:2] == 2'b00)
    else $error("legacy interrupt while controller enabled");

  a_stop_grant: assert property (
    (run && pins.stop_req) |=> stop_grant_ack_out && core_clk_gate_out)
    else $error("stop request not granted");

  // power state register sits between the pins and the core reset flop
  a_pg_reset: assert property (
    !pins.power_good |-> ##2 core_reset_out [*2])
    else $error("core not held in reset while power good low");

endmodule : csb_sideband

// File: csb_platform.sv
// csb_platform: platform pin model for the sideband block; passes bench commands to the pins, inverting stop and init onto the active-low pins
// assumes the bench commands levels just after core clock edges
`timescale 1ns/1ps
module csb_platform (
  // commands from the bench
  input wire logic pg_cmd_in,
  input wire logic stop_cmd_in,
  input wire logic init_cmd_in,
  input wire logic [1:0] irq_cmd_in,
  // pins toward the block
  output logic power_good_out,
  output logic stop_clock_request_n_out,
  output logic soft_init_n_out,
  output logic [1:0] local_irq_out
);
  // power good low from start, clean single steps only
  assign power_good_out = pg_cmd_in;
  assign stop_clock_request_n_out = ~stop_cmd_in;
  assign soft_init_n_out = ~init_cmd_in;
  assign local_irq_out = irq_cmd_in;
endmodule : csb_platform

// File: csb_sideband_tb.sv
// csb_sideband_tb: self-checking bench for the sideband control block
// assumes csb_pkg and csb_platform are compiled first
`timescale 1ns/1ps
module csb_sideband_tb;
  logic clk_in = 0, rst_in = 1, pg = 0, stp = 0, ini = 0, lic = 0;
  logic brk = 0, dp1 = 0, dp2 = 0, snp = 0;
  logic [1:0] irqp = 0, irq_w, cst;
  logic pg_w, stp_n_w, ini_n_w, pbo_n, oe_n, ack, gate, crst, irr, rstrt;
  logic sack;
  logic [31:0] faddr;
  logic [3:0] irq;
  int fail_count = 0, checks_done = 0;

  csb_platform plat (.pg_cmd_in(pg), .stop_cmd_in(stp), .init_cmd_in(ini),
    .irq_cmd_in(irqp), .power_good_out(pg_w),
    .stop_clock_request_n_out(stp_n_w), .soft_init_n_out(ini_n_w),
    .local_irq_out(irq_w));
  csb_sideband dut (.clk_in(clk_in), .rst_in(rst_in), .power_good_in(pg_w),
    .stop_clock_request_n_in(stp_n_w), .soft_init_n_in(ini_n_w),
    .local_irq_pin0_in(irq_w[0]), .local_irq_pin1_in(irq_w[1]),
    .lic_disable_in(lic), .break_event_in(brk), .deep_idle_req_in(dp1),
    .deepest_down_req_in(dp2), .snoop_req_in(snp),
    .pending_break_out_n(pbo_n), .pending_break_oe_n_out(oe_n),
    .stop_grant_ack_out(ack), .core_clk_gate_out(gate),
    .core_reset_out(crst), .int_reg_reset_out(irr),
    .fetch_restart_out(rstrt), .fetch_addr_out(faddr),
    .snoop_ack_out(sack), .irq_out(irq), .cstate_out(cst));

  initial forever #50 clk_in = ~clk_in;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : step

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic t_up;
    int n;
    n = 0;
    @(posedge clk_in);
    pg <= 1;
    step(1);
    while (crst !== 1'b0 && n < 40) begin
      step(1);
      n++;
    end
    chk(crst, 0);
    chk(n, csb_pkg::SYNC_STAGES + csb_pkg::RESET_SEQ_CYCLES + 1);
    chk(oe_n, 1);
    chk(irq, 0);
    $display("power up done");
  endtask : t_up

  task automatic t_break;
    @(posedge clk_in);
    brk <= 1;
    step(3);
    chk(oe_n, 1);
    chk(pbo_n, 0);
    @(posedge clk_in);
    brk <= 0;
    stp <= 1;
    step(3);
    chk({ack, gate, cst}, 4'hD);
    @(posedge clk_in);
    dp1 <= 1;
    step(2);
    chk(cst, 2);
    @(posedge clk_in);
    brk <= 1;
    step(1);
    chk(oe_n, 0);
    @(posedge clk_in);
    brk <= 0;
    dp2 <= 1;
    step(2);
    chk({oe_n, cst}, 3'h7);
    @(posedge clk_in);
    brk <= 1;
    step(2);
    chk(oe_n, 0);
    @(posedge clk_in);
    {stp, dp1, dp2} <= 3'h0;
    step(4);
    chk({oe_n, ack, cst}, 4'h8);
    @(posedge clk_in);
    brk <= 0;
    $display("break test done");
  endtask : t_break

  task automatic t_init;
    @(posedge clk_in);
    snp <= 1;
    ini <= 1;
    step(3);
    chk(irr, 1);
    chk(sack, 1);
    @(posedge clk_in);
    ini <= 0;
    step(3);
    chk({irr, rstrt}, 2'b01);
    chk(faddr, csb_pkg::RESET_VECTOR);
    step(1);
    chk(rstrt, 0);
    @(posedge clk_in);
    snp <= 0;
    step(1);
    chk(sack, 0);
    $display("soft init test done");
  endtask : t_init

  task automatic t_irq;
    logic [3:0] e;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_in);
      lic <= i[2];
      irqp <= i[1:0];
      step(3);
      e = i[2] ? {i[0], i[1], 2'b00} : {2'b00, i[0], i[1]};
      chk(irq, e);
    end
    @(posedge clk_in);
    lic <= 0;
    irqp <= 0;
    $display("interrupt test done");
  endtask : t_irq

  task automatic t_drop;
    @(posedge clk_in);
    pg <= 0;
    step(4);
    chk(crst, 1);
    chk(irr, 1);
    $display("power drop test done");
  endtask : t_drop

  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 0;
    t_up;
    t_break;
    t_init;
    t_irq;
    t_drop;
    t_up;
    report_and_stop;
  end

  initial begin
    #(3000 * csb_pkg::CLK_PERIOD_NS);
    fail_count++;
    report_and_stop;
  end
endmodule : csb_sideband_tb
